/* File: verilog/sbcu_store_unit.v */
// Purpose: Byte store, user-space byte store and conditional store execution
// Assumes: Pipeline holds req_* until req_ready; translation and memory
//          answer with one-cycle done pulses
// Notes: Registers reached over AHB-Lite, zero wait states
`timescale 1ns/1ps
`include "sbcu_regs.vh"

module sbcu_store_unit #(
    parameter EVA_PRESENT = 1,
    parameter BLOCK_BITS = 4
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire req_valid,
    output wire req_ready,
    input wire [1:0] req_op,
    input wire [31:0] req_base,
    input wire [15:0] req_offset,
    input wire [31:0] req_src,
    input wire [31:0] req_pc,
    output reg xlat_req,
    output reg [31:0] xlat_vaddr,
    output reg xlat_user_map,
    input wire xlat_done,
    input wire [31:0] xlat_paddr,
    input wire [2:0] xlat_cca,
    input wire [2:0] xlat_seg_mode,
    input wire [3:0] xlat_exc,
    output reg mem_req,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_data,
    output reg [3:0] mem_be,
    output reg [2:0] mem_cca,
    input wire mem_done,
    input wire mem_bus_err,
    input wire ll_valid,
    input wire [31:0] ll_pc,
    input wire [31:0] ll_paddr,
    input wire exception_return,
    input wire snoop_valid,
    input wire [31:0] snoop_paddr,
    input wire other_access,
    output reg wb_valid,
    output reg wb_write,
    output reg [31:0] wb_data,
    output reg [3:0] exc_code
);

    localparam ST_IDLE = 2'd0;
    localparam ST_XLAT = 2'd1;
    localparam ST_STORE = 2'd2;
    localparam ST_DONE = 2'd3;

    // ==========================================================
    // Register bus slave
    reg [3:0] ctrl_reg;
    reg [31:0] sc_ok_reg;
    reg [31:0] sc_fail_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire bus_take;
    wire [31:0] link_addr;
    wire link_flag;
    wire link_ok;
    reg [1:0] state_reg;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus_take = hsel && htrans[1] && hready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            ctrl_reg <= `SBCU_CTRL_RST;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_reg <= bus_take && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (wr_pend_reg && (wr_addr_reg == `SBCU_CTRL_OFS)) begin
                ctrl_reg <= hwdata[3:0];
            end
            // Read data is fetched in the address phase so it stands in the data phase
            if (bus_take && !hwrite) begin
                case (haddr[7:0])
                    `SBCU_CTRL_OFS: hrdata <= {28'h0000000, ctrl_reg};
                    `SBCU_CONFIG_OFS: hrdata <= (EVA_PRESENT != 0) ? 32'h00000001
                        : 32'h00000000;
                    `SBCU_STATUS_OFS: hrdata <= {30'h00000000, (state_reg != ST_IDLE),
                        link_flag};
                    `SBCU_LINK_ADDR_OFS: hrdata <= link_addr;
                    `SBCU_SC_OK_OFS: hrdata <= sc_ok_reg;
                    `SBCU_SC_FAIL_OFS: hrdata <= sc_fail_reg;
                    default: hrdata <= 32'h00000000;
                endcase
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    wire big_endian_core = ctrl_reg[`SBCU_CTRL_BIG_ENDIAN];
    wire reverse_endian_mode = ctrl_reg[`SBCU_CTRL_REV_ENDIAN];
    wire cp0_enabled = ctrl_reg[`SBCU_CTRL_CP0_EN];
    wire strict = ctrl_reg[`SBCU_CTRL_STRICT];

    // ==========================================================
    // Address forming
    wire [31:0] imm16_ext;
    wire [31:0] imm9_ext;
    wire [31:0] vaddr;
    wire eva_present;

    assign eva_present = (EVA_PRESENT != 0);
    assign imm16_ext = {{16{req_offset[15]}}, req_offset};
    assign imm9_ext = {{23{req_offset[8]}}, req_offset[8:0]};
    assign vaddr = req_base + ((req_op == `SBCU_OP_BYTE_USER) ? imm9_ext : imm16_ext);

    // ==========================================================
    // Execution sequence
    reg [1:0] op_reg;
    reg [31:0] src_reg;
    reg [31:0] pc_reg;
    reg sc_consume;
    reg [1:0] lane;
    wire seg_ok;

    // Only the three user-accessible kernel modes are allowed
    assign seg_ok = (xlat_seg_mode == `SBCU_SEG_MAPPED_USER_KERNEL_SEGMENT) ||
        (xlat_seg_mode == `SBCU_SEG_UNMAPPED_USER_KERNEL_SEGMENT) || (xlat_seg_mode == `SBCU_SEG_MAPPED_USER_SUPERVISOR_KERNEL_SEGMENT);
    assign req_ready = (state_reg == ST_IDLE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            op_reg <= `SBCU_OP_BYTE;
            src_reg <= 32'h00000000;
            pc_reg <= 32'h00000000;
            xlat_req <= 1'b0;
            xlat_vaddr <= 32'h00000000;
            xlat_user_map <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_data <= 32'h00000000;
            mem_be <= 4'h0;
            mem_cca <= 3'h0;
            wb_valid <= 1'b0;
            wb_write <= 1'b0;
            wb_data <= 32'h00000000;
            exc_code <= `SBCU_EXC_NONE;
            sc_consume <= 1'b0;
            sc_ok_reg <= 32'h00000000;
            sc_fail_reg <= 32'h00000000;
            lane <= 2'h0;
        end else begin
            sc_consume <= 1'b0;
            wb_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    wb_write <= 1'b0;
                    exc_code <= `SBCU_EXC_NONE;
                    if (req_valid) begin
                        op_reg <= req_op;
                        src_reg <= req_src;
                        pc_reg <= req_pc;
                        xlat_vaddr <= vaddr;
                        lane <= vaddr[1:0] ^ {2{big_endian_core}};
                        if ((req_op == `SBCU_OP_BYTE_USER) && !eva_present) begin
                            exc_code <= `SBCU_EXC_RESV;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end else if ((req_op == `SBCU_OP_BYTE_USER) && !cp0_enabled) begin
                            exc_code <= `SBCU_EXC_CPU;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end else if ((req_op == `SBCU_OP_COND) && (vaddr[1:0] != 2'h0)) begin
                            exc_code <= `SBCU_EXC_ADDR;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end else if (req_op == `SBCU_OP_BYTE || req_op == `SBCU_OP_BYTE_USER
                            || req_op == `SBCU_OP_COND) begin
                            xlat_req <= 1'b1;
                            xlat_user_map <= (req_op == `SBCU_OP_BYTE_USER);
                            state_reg <= ST_XLAT;
                        end else begin
                            // Unknown operation codes are refused as reserved
                            exc_code <= `SBCU_EXC_RESV;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_XLAT: begin
                    if (xlat_done) begin
                        xlat_req <= 1'b0;
                        if (xlat_exc != `SBCU_EXC_NONE) begin
                            // Translation faults pass through unchanged
                            exc_code <= xlat_exc;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end else if ((op_reg == `SBCU_OP_BYTE_USER) && !seg_ok) begin
                            exc_code <= `SBCU_EXC_RESV;
                            wb_valid <= 1'b1;
                            state_reg <= ST_DONE;
                        end else if (op_reg == `SBCU_OP_COND) begin
                            mem_cca <= xlat_cca;
                            mem_addr <= xlat_paddr;
                            if (link_ok) begin
                                mem_data <= src_reg;
                                mem_be <= 4'hF;
                                mem_req <= 1'b1;
                                state_reg <= ST_STORE;
                            end else begin
                                // No write; register receives zero
                                wb_data <= 32'h00000000;
                                wb_write <= 1'b1;
                                wb_valid <= 1'b1;
                                sc_consume <= 1'b1;
                                sc_fail_reg <= sc_fail_reg + 32'h00000001;
                                state_reg <= ST_DONE;
                            end
                        end else begin
                            mem_cca <= xlat_cca;
                            mem_addr <= {xlat_paddr[31:2],
                                xlat_paddr[1:0] ^ {2{reverse_endian_mode}}};
                            mem_data <= {24'h000000, src_reg[7:0]} << {lane, 3'b000};
                            mem_be <= 4'h1 << lane;
                            mem_req <= 1'b1;
                            state_reg <= ST_STORE;
                        end
                    end
                end
                ST_STORE: begin
                    if (mem_done) begin
                        mem_req <= 1'b0;
                        wb_valid <= 1'b1;
                        state_reg <= ST_DONE;
                        if (op_reg == `SBCU_OP_COND) begin
                            wb_data <= 32'h00000001;
                            wb_write <= 1'b1;
                            sc_consume <= 1'b1;
                            sc_ok_reg <= sc_ok_reg + 32'h00000001;
                        end else if (mem_bus_err) begin
                            exc_code <= `SBCU_EXC_BUS;
                        end
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Link tracking
    // Address equality between linked load and store is left to software
    sbcu_link_monitor #(
        .BLOCK_BITS(BLOCK_BITS)
    ) u_link (
        .hclk(hclk),
        .hresetn(hresetn),
        .ll_valid(ll_valid),
        .ll_pc(ll_pc),
        .ll_paddr(ll_paddr),
        .exception_return(exception_return),
        .snoop_valid(snoop_valid),
        .snoop_paddr(snoop_paddr),
        .other_access(other_access),
        .strict(strict),
        .sc_consume(sc_consume),
        .sc_pc(pc_reg),
        .link_flag(link_flag),
        .link_addr(link_addr),
        .link_ok(link_ok)
    );

endmodule

/* File: verilog/sbcu_regs.vh */
// Purpose: Constants of the store byte and conditional store unit
// Assumes: Included by every design file of the unit
// Notes: Offsets are byte addresses on the register bus
`ifndef SBCU_REGS_VH
`define SBCU_REGS_VH

// ==========================================================
// Register offsets
`define SBCU_CTRL_OFS 8'h00
`define SBCU_CONFIG_OFS 8'h04
`define SBCU_STATUS_OFS 8'h08
`define SBCU_LINK_ADDR_OFS 8'h0C
`define SBCU_SC_OK_OFS 8'h10
`define SBCU_SC_FAIL_OFS 8'h14

// ==========================================================
// Field positions
`define SBCU_CTRL_BIG_ENDIAN 0
`define SBCU_CTRL_REV_ENDIAN 1
`define SBCU_CTRL_CP0_EN 2
`define SBCU_CTRL_STRICT 3
`define SBCU_CONFIG_EVA 0
`define SBCU_STATUS_LINK 0
`define SBCU_STATUS_BUSY 1

// ==========================================================
// Reset values
`define SBCU_CTRL_RST 4'h4

// ==========================================================
// Operations
`define SBCU_OP_BYTE 2'h0
`define SBCU_OP_BYTE_USER 2'h1
`define SBCU_OP_COND 2'h2

// ==========================================================
// Segment access modes from translation
`define SBCU_SEG_MAPPED_USER_KERNEL_SEGMENT 3'h1
`define SBCU_SEG_UNMAPPED_USER_KERNEL_SEGMENT 3'h2
`define SBCU_SEG_MAPPED_USER_SUPERVISOR_KERNEL_SEGMENT 3'h3

// ==========================================================
// Exception codes
`define SBCU_EXC_NONE 4'h0
`define SBCU_EXC_REFILL 4'h1
`define SBCU_EXC_INVALID 4'h2
`define SBCU_EXC_MODIFIED 4'h3
`define SBCU_EXC_WATCH 4'h4
`define SBCU_EXC_ADDR 4'h5
`define SBCU_EXC_BUS 4'h6
`define SBCU_EXC_RESV 4'h7
`define SBCU_EXC_CPU 4'h8

// ==========================================================
// Region of the store distance check
`define SBCU_REGION_BYTES 2048
`define SBCU_REGION_BITS 11

`endif

/* File: verilog/sbcu_link_monitor.v */
// Purpose: Link flag and monitored block for the conditional store
// Assumes: One linked load at a time, pulses last one cycle
// Notes: A linked load in the same cycle as a clearing event wins
`timescale 1ns/1ps
`include "sbcu_regs.vh"

module sbcu_link_monitor #(
    parameter BLOCK_BITS = 4
) (
    input wire hclk,
    input wire hresetn,
    input wire ll_valid,
    input wire [31:0] ll_pc,
    input wire [31:0] ll_paddr,
    input wire exception_return,
    input wire snoop_valid,
    input wire [31:0] snoop_paddr,
    input wire other_access,
    input wire strict,
    input wire sc_consume,
    input wire [31:0] sc_pc,
    output reg link_flag,
    output reg [31:0] link_addr,
    output wire link_ok
);

    // ==========================================================
    // Clearing events
    reg [31:0] ll_pc_reg;
    wire [31:0] pc_dist;
    wire snoop_hit;
    wire clear_now;

    // Block compare ignores the low BLOCK_BITS address bits
    assign snoop_hit = snoop_valid &&
        (snoop_paddr[31:BLOCK_BITS] == link_addr[31:BLOCK_BITS]);
    // Intervening accesses fail only in strict mode; lax mode lets them pass
    assign clear_now = snoop_hit || exception_return || sc_consume ||
        (strict && other_access);
    assign pc_dist = sc_pc - ll_pc_reg;
    // Strict mode fails a store too far from its linked load
    assign link_ok = link_flag &&
        !(strict && (pc_dist[31:`SBCU_REGION_BITS] != 21'h000000));

    // ==========================================================
    // Link flag
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_flag <= 1'b0;
            link_addr <= 32'h00000000;
            ll_pc_reg <= 32'h00000000;
        end else if (ll_valid) begin
            link_flag <= 1'b1;
            link_addr <= ll_paddr;
            ll_pc_reg <= ll_pc;
        end else if (clear_now) begin
            link_flag <= 1'b0;
        end
    end

endmodule

/* File: test/sbcu_properties.sv */
// Purpose: Port checker for the store unit
// Assumes: One clock, hresetn asynchronous active low
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps
`include "sbcu_regs.vh"
module sbcu_properties (
    input logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input logic [1:0] htrans, req_op,
    input logic [31:0] hrdata, req_base, xlat_vaddr, mem_addr, mem_data, wb_data,
    input logic [15:0] req_offset,
    input logic req_valid, req_ready, xlat_req, xlat_done, mem_req, mem_done,
    input logic wb_valid, wb_write,
    input logic [3:0] mem_be, exc_code
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire [31:0] ea16 = req_base + {{16{req_offset[15]}}, req_offset};
    wire take = req_valid && req_ready;
    wire [31:0] lane_mask = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};
// ==========
// Assertions
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    a_rdata_phase: assert property (hrdata != 32'h0 |-> $past(hsel && htrans[1] && hready && !hwrite))
        else $error("read data outside a read data phase");
    a_wb_pulse: assert property (wb_valid |=> !wb_valid)
        else $error("finish pulse longer than one cycle");
    a_busy_refuse: assert property (xlat_req || mem_req || wb_valid |-> !req_ready)
        else $error("request accepted while busy");
    a_xlat_hold: assert property (xlat_req && !xlat_done |=> xlat_req && $stable(xlat_vaddr))
        else $error("translation request dropped early");
    a_mem_hold: assert property (mem_req && !mem_done |=>
        mem_req && $stable(mem_addr) && $stable(mem_data) && $stable(mem_be))
        else $error("memory request dropped early");
    a_byte_lane: assert property (mem_req && mem_be != 4'hF |->
        $onehot(mem_be) && (mem_data & ~lane_mask) == 32'h0)
        else $error("byte store data outside its lane");
    a_byte_addr: assert property (take && req_op == `SBCU_OP_BYTE |=>
        xlat_req && xlat_vaddr == $past(ea16))
        else $error("byte store address wrong");
    a_cond_addr: assert property (take && req_op == `SBCU_OP_COND && ea16[1:0] == 2'h0 |=>
        xlat_req && xlat_vaddr == $past(ea16))
        else $error("conditional store address wrong");
    a_misalign: assert property (take && req_op == `SBCU_OP_COND && ea16[1:0] != 2'h0 |=>
        !xlat_req ##[0:1] (wb_valid && exc_code == `SBCU_EXC_ADDR))
        else $error("misaligned conditional store not refused");
    a_cond_result: assert property (wb_valid && wb_write && exc_code == `SBCU_EXC_NONE |->
        wb_data == {31'h0, $past(mem_done)})
        else $error("conditional result disagrees with memory write");
endmodule

bind sbcu_store_unit sbcu_properties u_props (.hclk, .hresetn, .hsel, .hwrite, .hready,
    .hreadyout, .hresp, .htrans, .req_op, .hrdata, .req_base, .xlat_vaddr, .mem_addr, .mem_data,
    .wb_data, .req_offset, .req_valid, .req_ready, .xlat_req, .xlat_done, .mem_req, .mem_done,
    .wb_valid, .wb_write, .mem_be, .exc_code);

/* File: test/sbcu_far_side.sv */
// Purpose: Translation and memory model beyond the store unit
// Assumes: Requests held until done, one at a time
// Notes: Translation answers and mem_bus_err carry a changing pattern outside their done pulse
`timescale 1ns/1ps
module sbcu_far_side #(
    parameter [31:0] XOR_PADDR = 32'h4000_0000
) (
    input logic hclk, xlat_req, mem_req, cfg_bus_err,
    input logic [31:0] xlat_vaddr, mem_addr, mem_data,
    input logic [3:0] mem_be, cfg_exc,
    input logic [2:0] cfg_seg,
    input logic [7:0] cfg_wait,
    output logic xlat_done, mem_done, mem_bus_err,
    output logic [31:0] xlat_paddr, seen_addr, seen_data, seen_cnt,
    output logic [2:0] xlat_cca, xlat_seg_mode,
    output logic [3:0] xlat_exc, seen_be
);
    logic [7:0] cnt;
    initial begin
        {xlat_done, mem_done, mem_bus_err, cnt, seen_cnt} = '0;
        {xlat_paddr, xlat_cca, xlat_seg_mode, xlat_exc} = '0;
    end
// ==========
// Answers, delayed by cfg_wait cycles
    always @(posedge hclk) begin
        xlat_done <= 1'b0;
        mem_done <= 1'b0;
        // Stale answers must not look valid to the unit
        {xlat_paddr, xlat_cca, xlat_seg_mode, xlat_exc, mem_bus_err} <=
            ~{xlat_paddr, xlat_cca, xlat_seg_mode, xlat_exc, mem_bus_err};
        cnt <= 8'h0;
        if ((xlat_req && !xlat_done) || (mem_req && !mem_done)) begin
            cnt <= cnt + 8'h1;
        end
        if (xlat_req && !xlat_done && cnt == cfg_wait) begin
            xlat_done <= 1'b1;
            xlat_paddr <= xlat_vaddr ^ XOR_PADDR;
            xlat_cca <= 3'h5;
            xlat_seg_mode <= cfg_seg;
            xlat_exc <= cfg_exc;
        end
        if (mem_req && !mem_done && cnt == cfg_wait) begin
            mem_done <= 1'b1;
            mem_bus_err <= cfg_bus_err;
            seen_addr <= mem_addr;
            seen_data <= mem_data;
            seen_be <= mem_be;
            seen_cnt <= seen_cnt + 32'h1;
        end
    end
endmodule

/* File: test/store_byte_and_conditional_unit_bench.sv */
// Purpose: Self-checking bench of the store unit
// Assumes: Far side model answers translation and memory
// Notes: Registers over AHB-Lite, zero wait states
`timescale 1ns/1ps
`include "sbcu_regs.vh"
module store_byte_and_conditional_unit_bench;
    localparam [31:0] XP = 32'h4000_0000;
    localparam logic [3:0] EK [4] = '{4'h2, 4'h4, 4'h4, 4'h8};
    localparam logic [31:0] EA [4] = '{32'h0, 32'h8, 32'h10, 32'h0};
    localparam logic [31:0] EX [4] = '{32'h0, 32'h0, 32'h1, 32'h1};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0;
    logic ll_valid = 1'b0, exception_return = 1'b0, snoop_valid = 1'b0, other_access = 1'b0;
    logic cfg_bus_err = 1'b0;
    logic [1:0] htrans = 2'h0, req_op = 2'h0;
    logic [2:0] cfg_seg = 3'h1;
    logic [3:0] cfg_exc = 4'h0;
    logic [7:0] cfg_wait = 8'h0;
    logic [15:0] req_offset = 16'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, req_base = 32'h0, req_src = 32'h0;
    logic [31:0] req_pc = 32'h100, ev_addr = 32'h0, ll_pc = 32'hF8, rd, r_res, r_data;
    wire hreadyout, hresp, req_ready, xlat_req, xlat_done, mem_req, mem_done;
    wire mem_bus_err, wb_valid, wb_write, um;
    wire [31:0] hrdata, xlat_vaddr, xlat_paddr, mem_addr, mem_data, wb_data;
    wire [31:0] seen_addr, seen_data, seen_cnt;
    wire [2:0] xlat_cca, xlat_seg_mode, cca;
    wire [3:0] xlat_exc, mem_be, exc_code, seen_be;
    int miscompares = 0, tests_run = 0;

    always #2.5 hclk = ~hclk;
    sbcu_store_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req_valid, .req_ready, .req_op,
        .req_base, .req_offset, .req_src, .req_pc, .xlat_req, .xlat_vaddr, .xlat_user_map(um),
        .xlat_done, .xlat_paddr, .xlat_cca, .xlat_seg_mode, .xlat_exc, .mem_req, .mem_addr,
        .mem_data, .mem_be, .mem_cca(cca), .mem_done, .mem_bus_err, .ll_valid, .ll_pc,
        .ll_paddr(ev_addr), .exception_return, .snoop_valid, .snoop_paddr(ev_addr), .other_access,
        .wb_valid, .wb_write, .wb_data, .exc_code);
    sbcu_far_side far (.hclk, .xlat_req, .mem_req, .cfg_bus_err, .xlat_vaddr, .mem_addr,
        .mem_data, .mem_be, .cfg_exc, .cfg_seg, .cfg_wait, .xlat_done, .mem_done, .mem_bus_err,
        .xlat_paddr, .seen_addr, .seen_data, .seen_cnt, .xlat_cca, .xlat_seg_mode, .xlat_exc,
        .seen_be);
// ==========
// Bus and request tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic st(input logic [1:0] op, input logic [31:0] b, input logic [15:0] o,
                      input logic [31:0] s);
        int n;
        req_valid <= 1'b1;
        req_op <= op;
        req_base <= b;
        req_offset <= o;
        req_src <= s;
        do @(posedge hclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        #1;
        while (wb_valid !== 1'b1 && n < 64) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk("finish pulse", 32'h1, {31'h0, wb_valid});
        r_res = {27'h0, wb_write, exc_code};
        r_data = wb_data;
        // Unit stays refused for one cycle after finishing
        @(posedge hclk);
        @(posedge hclk);
    endtask
    task automatic evt(input logic [3:0] k, input logic [31:0] a);
        ll_valid <= k[0];
        exception_return <= k[1];
        snoop_valid <= k[2];
        other_access <= k[3];
        ev_addr <= a;
        @(posedge hclk);
        {ll_valid, exception_return, snoop_valid, other_access} <= 4'h0;
        @(posedge hclk);
    endtask
// ==========
// Scenarios
    task automatic t_regs();
        ahb(1'b0, `SBCU_CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h4, rd);
        ahb(1'b1, `SBCU_CONFIG_OFS, 32'h0);
        ahb(1'b0, `SBCU_CONFIG_OFS, 32'h0);
        chk("config", 32'h1, rd);
        ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_byte();
        logic [31:0] va;
        logic [1:0] ln;
        logic [7:0] by;
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, `SBCU_CTRL_OFS, {29'h1, m[1:0]});
            for (int l = 0; l < 4; l++) begin
                va = 32'h1000_0000 + l;
                ln = l[1:0] ^ {2{m[0]}};
                by = 8'h11 * l[1:0];
                cfg_wait <= {6'h0, l[1:0]};
                st(`SBCU_OP_BYTE, va + 32'h10, 16'hFFF0, {24'h123456, by});
                chk("byte addr", (va ^ XP) ^ {30'h0, {2{m[1]}}}, seen_addr);
                chk("byte data", {24'h0, by} << (8 * ln), seen_data);
                chk("byte lane", {28'h0, 4'h1 << ln}, {28'h0, seen_be});
                chk("byte result", 32'h0, r_res);
            end
        end
        ahb(1'b1, `SBCU_CTRL_OFS, 32'h4);
        for (int e = 1; e < 5; e++) begin
            cfg_exc <= e[3:0];
            st(`SBCU_OP_BYTE, 32'h1000_0000, 16'h0, 32'h0);
            chk("byte fault", {28'h0, e[3:0]}, r_res);
        end
        cfg_exc <= 4'h0;
        cfg_bus_err <= 1'b1;
        st(`SBCU_OP_BYTE, 32'h1000_0000, 16'h0, 32'h0);
        chk("bus error", 32'h6, r_res);
        cfg_bus_err <= 1'b0;
        $display("test byte done");
    endtask
    task automatic t_user();
        for (int s = 0; s < 5; s++) begin
            cfg_seg <= s[2:0];
            st(`SBCU_OP_BYTE_USER, 32'h2000_0005, 16'h7FFF, 32'h0000_00C3);
            chk("user seg", (s >= 1 && s <= 3) ? 32'h0 : 32'h7, r_res);
        end
        chk("user addr", 32'h6000_0004, seen_addr);
        chk("user data", 32'h0000_00C3, seen_data);
        chk("user map", 32'h1, {31'h0, um});
        st(2'h3, 32'h0, 16'h0, 32'h0);
        chk("op reserved", 32'h7, r_res);
        cfg_seg <= 3'h1;
        ahb(1'b1, `SBCU_CTRL_OFS, 32'h0);
        st(`SBCU_OP_BYTE_USER, 32'h2000_0005, 16'h7FFF, 32'h0);
        chk("user cp0", 32'h8, r_res);
        ahb(1'b1, `SBCU_CTRL_OFS, 32'h4);
        $display("test user done");
    endtask
    task automatic t_cond();
        logic [31:0] pa, n;
        pa = 32'h7000_0010;
        evt(4'h1, pa);
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h8765_4321);
        chk("sc result", 32'h10, r_res);
        chk("sc flag", 32'h1, r_data);
        chk("sc word", 32'h8765_4321, seen_data);
        chk("sc addr", pa, seen_addr);
        chk("sc lanes", 32'hF, {28'h0, seen_be});
        chk("sc map", 32'h0, {31'h0, um});
        chk("sc cca", 32'h5, {29'h0, cca});
        n = seen_cnt;
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h1);
        chk("sc no link", 32'h0, r_data);
        chk("sc no write", n, seen_cnt);
        for (int i = 0; i < 4; i++) begin
            evt(4'h1, pa);
            evt(EK[i], pa + EA[i]);
            st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h2);
            chk("sc event", EX[i], r_data);
        end
        ahb(1'b1, `SBCU_CTRL_OFS, 32'hC);
        evt(4'h1, pa);
        evt(4'h8, pa);
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h3);
        chk("sc strict access", 32'h0, r_data);
        evt(4'h1, pa);
        req_pc <= 32'h900;
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h4);
        chk("sc far pc", 32'h0, r_data);
        req_pc <= 32'h100;
        ahb(1'b1, `SBCU_CTRL_OFS, 32'h4);
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0012, 32'h5);
        chk("sc misaligned", 32'h5, r_res & 32'hF);
        cfg_exc <= 4'h1;
        evt(4'h1, pa);
        st(`SBCU_OP_COND, 32'h3000_0000, 16'h0010, 32'h6);
        chk("sc refill", 32'h1, r_res & 32'hF);
        cfg_exc <= 4'h0;
        $display("test cond done");
    endtask
// ==========
// Sequence and verdict
    task automatic stop_test();
        $display("compared %0d, mismatched %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_byte();
        t_user();
        t_cond();
        stop_test();
    end
    // About 420 cycles are expected; far more means a hang
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
